// ### pkg/ofm_pkg.sv
/*
 * ofm_pkg: constants shared by the oscillation frequency monitor design.
 * Assumes the register bus carries 32-bit byte addresses and 32-bit data.
 */
//----------------------------------------------------------------------
//----------------------------------------------------------------------

package ofm_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int KEY_W = 8;
    localparam int LIMIT_W = 9;
    localparam int COUNT_W = 10;
    localparam int WINDOW_CYCLES = 128;
    localparam int WINDOW_W = 7;

    localparam logic [ADDR_W-1:0] ADDR_WRITE_PROTECT_KEY = 32'h4004_0800;
    localparam logic [ADDR_W-1:0] ADDR_DETECTION_CONTROL_KEY = 32'h4004_0804;
    localparam logic [ADDR_W-1:0] ADDR_LOWER_LIMIT_PLL_OFF = 32'h4004_0808;
    localparam logic [ADDR_W-1:0] ADDR_LOWER_LIMIT_PLL_ON = 32'h4004_080c;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_PLL_OFF = 32'h4004_0810;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_PLL_ON = 32'h4004_0814;
    localparam logic [ADDR_W-1:0] ADDR_MONITOR_STATUS = 32'h4004_0818;

    localparam logic [KEY_W-1:0] KEY_LOCK = 8'h06;
    localparam logic [KEY_W-1:0] KEY_UNLOCK = 8'hf9;
    localparam logic [KEY_W-1:0] CTRL_DISABLE = 8'h00;
    localparam logic [KEY_W-1:0] CTRL_ENABLE = 8'he4;

    localparam logic [LIMIT_W-1:0] RST_LOWER_PLL_OFF = 9'h01a;
    localparam logic [LIMIT_W-1:0] RST_LOWER_PLL_ON = 9'h0d1;
    localparam logic [LIMIT_W-1:0] RST_UPPER_PLL_OFF = 9'h028;
    localparam logic [LIMIT_W-1:0] RST_UPPER_PLL_ON = 9'h139;

    // status register bit positions
    localparam int STAT_FAULT = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_PAIR_ON = 2;
    localparam int STAT_STOPPED = 3;
    localparam int STAT_COUNT_LSB = 16;

endpackage

// ### pkg/ofm_mon_if.sv
/*
 * ofm_mon_if: carries measurement windows and fault decisions between
 * the frequency counter, the persistence filter and the monitor top.
 * Assumes all three parties run on the same reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface ofm_mon_if #(
    parameter int COUNT_W = 10
);
    logic run;
    logic win_done;
    logic [COUNT_W-1:0] win_count;
    logic bad;
    logic fault;

    modport counter (input run, output win_done, output win_count);
    modport persist (input run, input win_done, input bad, output fault);
    modport ctrl (output run, output bad, input win_done, input win_count, input fault);
endinterface

`default_nettype wire

// ### rtl/ofm_freq_counter.sv
/*
 * ofm_freq_counter: counts rising edges of the target clock divided by
 * four over fixed windows of reference clock cycles.
 * Assumes the divided target clock arrives asynchronously on a pin.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_freq_counter #(
    parameter int COUNT_W = 10
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // divided target clock
    input wire logic target_div4_i,
    // measurement carrier
    ofm_mon_if.counter mon
);
    logic sync_a;
    logic sync_b;
    logic sync_prev;
    logic [ofm_pkg::WINDOW_W-1:0] win_cnt;
    logic [COUNT_W-1:0] edge_cnt;
    logic done;
    logic [COUNT_W-1:0] result;
    logic [ofm_pkg::WINDOW_W-1:0] next_win_cnt;
    logic [COUNT_W-1:0] next_edge_cnt;
    logic next_done;
    logic [COUNT_W-1:0] next_result;
    logic rise;

    //------------------------------------------------------------------
    // window counting
    //------------------------------------------------------------------
    // sampling at the reference rate bounds the measurable target rate;
    // the edge count saturates rather than wrapping into a false low
    always_comb begin
        rise = sync_b & ~sync_prev;
        next_win_cnt = win_cnt;
        next_edge_cnt = edge_cnt;
        next_done = 1'b0;
        next_result = result;
        if (!mon.run) begin
            next_win_cnt = '0;
            next_edge_cnt = '0;
        end else begin
            next_win_cnt = win_cnt + 1'b1;
            if (win_cnt == ofm_pkg::WINDOW_W'(ofm_pkg::WINDOW_CYCLES - 1)) begin
                next_done = 1'b1;
                next_result = edge_cnt + COUNT_W'(rise);
                if (rise && (&edge_cnt)) begin
                    next_result = edge_cnt;
                end
                next_edge_cnt = '0;
            end else if (rise && !(&edge_cnt)) begin
                next_edge_cnt = edge_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        sync_a <= target_div4_i;
        sync_b <= sync_a;
        if (sys_rst_i) begin
            sync_prev <= 1'b0;
            win_cnt <= '0;
            edge_cnt <= '0;
            done <= 1'b0;
            result <= '0;
        end else begin
            sync_prev <= sync_b;
            win_cnt <= next_win_cnt;
            edge_cnt <= next_edge_cnt;
            done <= next_done;
            result <= next_result;
        end
    end

    assign mon.win_done = done;
    assign mon.win_count = result;
endmodule

`default_nettype wire

// ### rtl/ofm_persist.sv
/*
 * ofm_persist: filters window verdicts so, while run is high, the fault only
 * changes state after the same verdict persists for a number of windows.
 * Assumes verdicts arrive with a one-cycle window-done pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_persist #(
    parameter int PERSIST_WINDOWS = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // measurement carrier
    ofm_mon_if.persist mon
);
    localparam int CNT_W = $clog2(PERSIST_WINDOWS + 1);

    logic fault;
    logic [CNT_W-1:0] cnt;
    logic next_fault;
    logic [CNT_W-1:0] next_cnt;

    //------------------------------------------------------------------
    // persistence filter
    //------------------------------------------------------------------
    always_comb begin
        next_fault = fault;
        next_cnt = cnt;
        if (!mon.run) begin
            // suspended monitoring never holds or raises a fault
            next_fault = 1'b0;
            next_cnt = '0;
        end else if (mon.win_done) begin
            if (mon.bad != fault) begin
                if (cnt == CNT_W'(PERSIST_WINDOWS - 1)) begin
                    next_fault = mon.bad;
                    next_cnt = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end else begin
                // a single contrary window restarts the count
                next_cnt = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fault <= 1'b0;
            cnt <= '0;
        end else begin
            fault <= next_fault;
            cnt <= next_cnt;
        end
    end

    assign mon.fault = fault;
endmodule

`default_nettype wire

// ### rtl/ofm_top.sv
/*
 * ofm_top: oscillation frequency monitor with key-protected registers,
 * limit pair selection, mode gating and the monitor reset outputs.
 * Assumes sys_rst_i is the combined pin, power-on and supply-detect reset,
 * mode and pll inputs come from logic on sys_clk_i, and the divided
 * target clock arrives asynchronously.
 */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module ofm_top #(
    parameter int PERSIST_WINDOWS = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [ofm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ofm_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ofm_pkg::DATA_W-1:0] rd_data_o,
    // clock system state
    input wire logic target_div4_i,
    input wire logic pll_enable_i,
    input wire logic stop_mode_i,
    input wire logic warmup_i,
    // reset outputs
    output logic mon_reset_o,
    output logic io_hiz_o,
    output logic core_reset_o,
    output logic monitor_active_o
);
    logic [ofm_pkg::KEY_W-1:0] write_protect_key;
    logic [ofm_pkg::KEY_W-1:0] detection_control_key;
    logic [ofm_pkg::LIMIT_W-1:0] lower_limit_pll_off;
    logic [ofm_pkg::LIMIT_W-1:0] lower_limit_pll_on;
    logic [ofm_pkg::LIMIT_W-1:0] upper_limit_pll_off;
    logic [ofm_pkg::LIMIT_W-1:0] upper_limit_pll_on;
    logic force_off_pair;
    logic stopped;
    logic [ofm_pkg::COUNT_W-1:0] last_count;

    logic [ofm_pkg::KEY_W-1:0] next_write_protect_key;
    logic [ofm_pkg::KEY_W-1:0] next_detection_control_key;
    logic [ofm_pkg::LIMIT_W-1:0] next_lower_limit_pll_off;
    logic [ofm_pkg::LIMIT_W-1:0] next_lower_limit_pll_on;
    logic [ofm_pkg::LIMIT_W-1:0] next_upper_limit_pll_off;
    logic [ofm_pkg::LIMIT_W-1:0] next_upper_limit_pll_on;
    logic next_force_off_pair;
    logic next_stopped;
    logic [ofm_pkg::COUNT_W-1:0] next_last_count;
    logic [ofm_pkg::DATA_W-1:0] next_rd_data;
    logic next_mon_reset;
    logic next_io_hiz;
    logic next_core_reset;
    logic next_monitor_active;

    logic unlocked;
    logic enabled;
    logic limits_writable;
    logic [ofm_pkg::KEY_W-1:0] wr_byte;
    logic [ofm_pkg::LIMIT_W-1:0] wr_limit;
    logic pair_on;
    logic [ofm_pkg::LIMIT_W-1:0] act_lower;
    logic [ofm_pkg::LIMIT_W-1:0] act_upper;
    logic fault_rise;
    logic fault_prev;

    ofm_mon_if #(.COUNT_W(ofm_pkg::COUNT_W)) mon ();

    ofm_freq_counter #(
        .COUNT_W(ofm_pkg::COUNT_W)
    ) u_counter (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .target_div4_i(target_div4_i),
        .mon(mon.counter)
    );

    ofm_persist #(
        .PERSIST_WINDOWS(PERSIST_WINDOWS)
    ) u_persist (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .mon(mon.persist)
    );

    //------------------------------------------------------------------
    // detection gating and limit selection
    //------------------------------------------------------------------
    // the monitor's own reset is not fed back here, so detection keeps
    // running while it holds the chip in reset
    always_comb begin
        unlocked = (write_protect_key == ofm_pkg::KEY_UNLOCK);
        enabled = (detection_control_key == ofm_pkg::CTRL_ENABLE);
        limits_writable = unlocked && !enabled;
        mon.run = enabled && !stop_mode_i && !warmup_i;
        pair_on = pll_enable_i && !force_off_pair;
        act_lower = pair_on ? lower_limit_pll_on : lower_limit_pll_off;
        act_upper = pair_on ? upper_limit_pll_on : upper_limit_pll_off;
        // zero-extend limits to the count width for the comparison
        mon.bad = (mon.win_count == '0)
            || (mon.win_count < ofm_pkg::COUNT_W'(act_lower))
            || (mon.win_count > ofm_pkg::COUNT_W'(act_upper));
        fault_rise = mon.fault && !fault_prev;
    end

    //------------------------------------------------------------------
    // register writes
    //------------------------------------------------------------------
    always_comb begin
        wr_byte = wr_data_i[ofm_pkg::KEY_W-1:0];
        wr_limit = wr_data_i[ofm_pkg::LIMIT_W-1:0];
        next_write_protect_key = write_protect_key;
        next_detection_control_key = detection_control_key;
        next_lower_limit_pll_off = lower_limit_pll_off;
        next_lower_limit_pll_on = lower_limit_pll_on;
        next_upper_limit_pll_off = upper_limit_pll_off;
        next_upper_limit_pll_on = upper_limit_pll_on;
        if (wr_i) begin
            unique case (addr_i)
                ofm_pkg::ADDR_WRITE_PROTECT_KEY: begin
                    if (wr_byte == ofm_pkg::KEY_UNLOCK) begin
                        next_write_protect_key = ofm_pkg::KEY_UNLOCK;
                    end else begin
                        next_write_protect_key = ofm_pkg::KEY_LOCK;
                    end
                end
                ofm_pkg::ADDR_DETECTION_CONTROL_KEY: begin
                    if (unlocked && (wr_byte == ofm_pkg::CTRL_ENABLE
                            || wr_byte == ofm_pkg::CTRL_DISABLE)) begin
                        next_detection_control_key = wr_byte;
                    end
                end
                ofm_pkg::ADDR_LOWER_LIMIT_PLL_OFF: begin
                    if (limits_writable) begin
                        next_lower_limit_pll_off = wr_limit;
                    end
                end
                ofm_pkg::ADDR_LOWER_LIMIT_PLL_ON: begin
                    if (limits_writable) begin
                        next_lower_limit_pll_on = wr_limit;
                    end
                end
                ofm_pkg::ADDR_UPPER_LIMIT_PLL_OFF: begin
                    if (limits_writable) begin
                        next_upper_limit_pll_off = wr_limit;
                    end
                end
                ofm_pkg::ADDR_UPPER_LIMIT_PLL_ON: begin
                    if (limits_writable) begin
                        next_upper_limit_pll_on = wr_limit;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // register reads
    //------------------------------------------------------------------
    always_comb begin
        next_rd_data = '0;
        if (rd_i) begin
            unique case (addr_i)
                ofm_pkg::ADDR_WRITE_PROTECT_KEY:
                    next_rd_data = ofm_pkg::DATA_W'(write_protect_key);
                ofm_pkg::ADDR_DETECTION_CONTROL_KEY:
                    next_rd_data = ofm_pkg::DATA_W'(detection_control_key);
                ofm_pkg::ADDR_LOWER_LIMIT_PLL_OFF:
                    next_rd_data = ofm_pkg::DATA_W'(lower_limit_pll_off);
                ofm_pkg::ADDR_LOWER_LIMIT_PLL_ON:
                    next_rd_data = ofm_pkg::DATA_W'(lower_limit_pll_on);
                ofm_pkg::ADDR_UPPER_LIMIT_PLL_OFF:
                    next_rd_data = ofm_pkg::DATA_W'(upper_limit_pll_off);
                ofm_pkg::ADDR_UPPER_LIMIT_PLL_ON:
                    next_rd_data = ofm_pkg::DATA_W'(upper_limit_pll_on);
                ofm_pkg::ADDR_MONITOR_STATUS: begin
                    next_rd_data[ofm_pkg::STAT_FAULT] = mon_reset_o;
                    next_rd_data[ofm_pkg::STAT_ACTIVE] = monitor_active_o;
                    next_rd_data[ofm_pkg::STAT_PAIR_ON] = pair_on;
                    next_rd_data[ofm_pkg::STAT_STOPPED] = stopped;
                    next_rd_data[ofm_pkg::STAT_COUNT_LSB +: ofm_pkg::COUNT_W] = last_count;
                end
                default:
                    next_rd_data = '0;
            endcase
        end
    end

    //------------------------------------------------------------------
    // fault outputs and pair override
    //------------------------------------------------------------------
    always_comb begin
        next_last_count = last_count;
        next_stopped = stopped;
        if (mon.win_done) begin
            next_last_count = mon.win_count;
            next_stopped = (mon.win_count == '0);
        end
        if (!mon.run) begin
            next_stopped = 1'b0;
        end
        // the override drops only when software turns the pll off; a new
        // fault in the same cycle does not keep it set
        next_force_off_pair = force_off_pair;
        if (!pll_enable_i) begin
            next_force_off_pair = 1'b0;
        end
        if (fault_rise && pll_enable_i) begin
            next_force_off_pair = 1'b1;
        end
        next_mon_reset = mon.fault;
        next_io_hiz = mon.fault;
        // core logic is reset only while its clock still runs; with the
        // oscillator stopped it keeps the state it had at detection
        next_core_reset = mon.fault && !next_stopped;
        next_monitor_active = mon.run;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            write_protect_key <= ofm_pkg::KEY_LOCK;
            detection_control_key <= ofm_pkg::CTRL_DISABLE;
            lower_limit_pll_off <= ofm_pkg::RST_LOWER_PLL_OFF;
            lower_limit_pll_on <= ofm_pkg::RST_LOWER_PLL_ON;
            upper_limit_pll_off <= ofm_pkg::RST_UPPER_PLL_OFF;
            upper_limit_pll_on <= ofm_pkg::RST_UPPER_PLL_ON;
            force_off_pair <= 1'b0;
            stopped <= 1'b0;
            last_count <= '0;
            fault_prev <= 1'b0;
            rd_data_o <= '0;
            mon_reset_o <= 1'b0;
            io_hiz_o <= 1'b0;
            core_reset_o <= 1'b0;
            monitor_active_o <= 1'b0;
        end else begin
            write_protect_key <= next_write_protect_key;
            detection_control_key <= next_detection_control_key;
            lower_limit_pll_off <= next_lower_limit_pll_off;
            lower_limit_pll_on <= next_lower_limit_pll_on;
            upper_limit_pll_off <= next_upper_limit_pll_off;
            upper_limit_pll_on <= next_upper_limit_pll_on;
            force_off_pair <= next_force_off_pair;
            stopped <= next_stopped;
            last_count <= next_last_count;
            fault_prev <= mon.fault;
            rd_data_o <= next_rd_data;
            mon_reset_o <= next_mon_reset;
            io_hiz_o <= next_io_hiz;
            core_reset_o <= next_core_reset;
            monitor_active_o <= next_monitor_active;
        end
    end
endmodule

`default_nettype wire

// ### bench/ofm_top_chk_assertions.sv
/*
 * ofm_top_chk: port-level assertions for the frequency monitor top.
 * Assumes it is bound into ofm_top with the same PERSIST_WINDOWS.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_top_chk #(
    parameter int PERSIST_WINDOWS = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [ofm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ofm_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ofm_pkg::DATA_W-1:0] rd_data_o,
    // clock system state
    input wire logic target_div4_i,
    input wire logic pll_enable_i,
    input wire logic stop_mode_i,
    input wire logic warmup_i,
    // reset outputs
    input wire logic mon_reset_o,
    input wire logic io_hiz_o,
    input wire logic core_reset_o,
    input wire logic monitor_active_o
);
    // a few cycles of slack for the synchroniser and window start
    localparam int SET_MIN = PERSIST_WINDOWS * 128 - 4;
    logic [11:0] act_cnt;
    logic [11:0] hi_cnt;
    logic [11:0] next_act_cnt;
    logic [11:0] next_hi_cnt;

    always_comb begin
        next_act_cnt = monitor_active_o ? act_cnt + {11'h000, act_cnt != 12'hfff} : 12'h000;
        next_hi_cnt = mon_reset_o ? hi_cnt + {11'h000, hi_cnt != 12'hfff} : 12'h000;
    end

    always_ff @(posedge sys_clk_i) begin
        act_cnt <= sys_rst_i ? 12'h000 : next_act_cnt;
        hi_cnt <= sys_rst_i ? 12'h000 : next_hi_cnt;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_rd_idle; !$past(rd_i) |-> rd_data_o == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_hiz; io_hiz_o == mon_reset_o; endproperty
    a_hiz: assert property (p_hiz) else $error("float differs from monitor reset");
    property p_core; core_reset_o |-> mon_reset_o; endproperty
    a_core: assert property (p_core) else $error("core reset without monitor reset");
    property p_reset;
        disable iff (1'b0) sys_rst_i |=> !mon_reset_o && !monitor_active_o && rd_data_o == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_act_stop; stop_mode_i || warmup_i |=> !monitor_active_o; endproperty
    a_act_stop: assert property (p_act_stop) else $error("active in stop or warm-up");
    property p_stop_quiet; (stop_mode_i || warmup_i) [*3] |-> !mon_reset_o; endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("fault in stop or warm-up");
    property p_set; $rose(mon_reset_o) |-> act_cnt >= SET_MIN; endproperty
    a_set: assert property (p_set) else $error("fault set too early");
    property p_rel; $fell(mon_reset_o) && monitor_active_o |-> hi_cnt >= SET_MIN; endproperty
    a_rel: assert property (p_rel) else $error("fault released too early");
endmodule

bind ofm_top ofm_top_chk #(.PERSIST_WINDOWS(PERSIST_WINDOWS)) u_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .target_div4_i(target_div4_i),
    .pll_enable_i(pll_enable_i), .stop_mode_i(stop_mode_i), .warmup_i(warmup_i),
    .mon_reset_o(mon_reset_o), .io_hiz_o(io_hiz_o), .core_reset_o(core_reset_o),
    .monitor_active_o(monitor_active_o)
);

`default_nettype wire

// ### bench/ofm_osc_model.sv
/*
 * ofm_osc_model: the oscillator seen through its divide-by-four tap.
 * Assumes the bench sets the half period in ns; a stopped oscillator holds still.
 */
`timescale 1ns/1ps
`default_nettype none

module ofm_osc_model (
    // oscillator control
    input wire logic run_i,
    input var int half_ns_i,
    // divided target clock
    output logic target_div4_o
);
    initial target_div4_o = 1'b0;
    always begin
        if (run_i) #(half_ns_i) target_div4_o = ~target_div4_o;
        else #(100);
    end
endmodule

`default_nettype wire

// ### bench/tb.sv
/*
 * tb: register and fault scenarios for the frequency monitor.
 * Assumes a 10 MHz reference; 200 ns half period gives a count near 32.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [31:0] KA = ofm_pkg::ADDR_WRITE_PROTECT_KEY;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pll = 1'b0, stp = 1'b0, wup = 1'b0;
    logic [31:0] addr = 32'h0, wdat = 32'h0, rdat;
    logic tgt, mrst, hiz, crst, act, osc = 1'b1;
    int half = 200, bad_count = 0, tests_run = 0;
    logic [31:0] rv [4] = '{32'h01a, 32'h0d1, 32'h028, 32'h139};
    // off limits bracket 32 counts: target 10 MHz +-10%, reference 8.5 to 10.5 MHz
    logic [31:0] lim [4] = '{32'h21c, 32'h0d0, 32'h029, 32'h130};

    always #50 clk = ~clk;
    ofm_osc_model osc_m (.run_i(osc), .half_ns_i(half), .target_div4_o(tgt));
    ofm_top #(.PERSIST_WINDOWS(2)) uut (
        .sys_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdat), .target_div4_i(tgt), .pll_enable_i(pll),
        .stop_mode_i(stp), .warmup_i(wup), .mon_reset_o(mrst), .io_hiz_o(hiz),
        .core_reset_o(crst), .monitor_active_o(act)
    );

    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wrt(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wdat <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    // bounded wait: three windows to flip plus margin
    task waitm(input logic e);
        int n;
        n = 0;
        // look a step after each edge so the launching edge never races the test
        while (mrst !== e && n < 800) begin
            @(posedge clk);
            #1 n++;
        end
        chk({31'h0, mrst}, {31'h0, e});
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(KA, 32'h06);
        rdc(KA + 4, 32'h00);
        for (int i = 0; i < 4; i++) rdc(KA + 8 + 4 * i, rv[i]);
        rdc(KA + 32'h1c, 32'h0);
        $display("reset values test done");
        wrt(KA + 8, 32'h55); rdc(KA + 8, rv[0]);
        wrt(KA + 4, 32'he4); rdc(KA + 4, 32'h00);
        wrt(KA, 32'h12); rdc(KA, 32'h06);
        wrt(KA, 32'hf9); rdc(KA, 32'hf9);
        for (int i = 0; i < 4; i++) begin
            wrt(KA + 8 + 4 * i, lim[i]);
            rdc(KA + 8 + 4 * i, lim[i] & 32'h1ff);
        end
        wrt(KA + 4, 32'h33); rdc(KA + 4, 32'h00);
        wrt(KA + 4, 32'he4); rdc(KA + 4, 32'he4);
        wrt(KA + 8, 32'h07); rdc(KA + 8, 32'h01c);
        wrt(KA, 32'h06);
        $display("register lock test done");
        repeat (600) @(posedge clk);
        #1 chk({mrst, act}, 2'b01);
        half = 640; waitm(1'b1);
        chk({hiz, crst}, 2'b11);
        half = 200; waitm(1'b0);
        osc = 1'b0; waitm(1'b1);
        chk({31'h0, crst}, 32'h0);
        rdc(KA + 32'h18, 32'h0000_000b);
        osc = 1'b1; waitm(1'b0);
        $display("fault test done");
        half = 640;
        @(posedge clk);
        stp <= 1'b1;
        repeat (600) @(posedge clk);
        #1 chk({mrst, act}, 2'b00);
        half = 200;
        @(posedge clk);
        stp <= 1'b0;
        wup <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({31'h0, act}, 32'h0);
        @(posedge clk);
        wup <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({31'h0, act}, 32'h1);
        @(posedge clk);
        pll <= 1'b1;
        waitm(1'b1);
        waitm(1'b0);
        @(posedge clk);
        pll <= 1'b0;
        $display("mode and pll test done");
        half = 640; waitm(1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({31'h0, mrst}, 32'h0);
        half = 200;
        @(posedge clk);
        rst <= 1'b0;
        rdc(KA + 4, 32'h00);
        rdc(KA + 8, rv[0]);
        wrt(KA, 32'hf9); wrt(KA + 4, 32'he4); rdc(KA + 4, 32'he4);
        wrt(KA + 4, 32'h00); rdc(KA + 4, 32'h00);
        $display("mid-fault reset test done");
        final_report;
    end

    initial begin
        #2_000_000;
        bad_count++;
        final_report;
    end
endmodule

`default_nettype wire
